// file: design/hpct_pkg.sv
// hpct_pkg: constants and carrier types for the hub port change tracker
// assumes one hub clock and a synchronous active-high hub reset
//
// Overview of operation
// [R1] each change flag stays set until its own clear request, its force-zero condition (R4 R9 R10 R12) or a hub reset.
// [R2] set requests for change flags are honoured only when diagnostic set is enabled, else a no-op.
// [R3] the connect change flag in bit 0 sets when connect status changes on attach or detach.
// [R4] the connect change flag clears on its clear request and stays zero while powered off.
// [R5] the enable change flag in bit 1 sets when enable falls because of a port error.
// [R6] the enable change flag may also set when a port reset leaves the port disabled on bad idle.
// [R7] the suspend change flag in bit 2 sets on resume completion transitions, after resume drive ends.
// [R8] the over-current change flag in bit 3 sets on each over-current edge or remote power-off.
// [R9] the over-current change flag clears while not configured or on its clear request.
// [R10] without per-port over-current reporting the over-current change flag reads zero.
// [R11] the reset change flag in bit 4 sets when the port goes from resetting or speed eval to enabled.
// [R12] enable, suspend and reset change flags clear on their own request and stay zero powered off.
// [R13] bits 5 through 15 of the change word always read zero.
// [R14] a set event and a clear in the same cycle leave the flag set.
package hpct_pkg;

	localparam int        CHG_NUM       = 5;
	localparam int        WORD_W        = 16;
	localparam int        BIT_CONNECT   = 0;
	localparam int        BIT_ENABLE    = 1;
	localparam int        BIT_SUSPEND   = 2;
	localparam int        BIT_OVERCUR   = 3;
	localparam int        BIT_RESET     = 4;
	localparam logic [4:0] CHG_RESET_VAL = 5'h0_0;

	// port state machine state codes as seen by this block
	typedef enum logic [3:0] {
		PS_POWERED_OFF = 4'h0,
		PS_DISCONNECTED = 4'h1,
		PS_DISABLED    = 4'h2,
		PS_RESETTING   = 4'h3,
		PS_SPEED_EVAL  = 4'h4,
		PS_ENABLED     = 4'h5,
		PS_TRANSMIT    = 4'h6,
		PS_SUSPENDED   = 4'h7,
		PS_RESUMING    = 4'h8,
		PS_SEND_EOP    = 4'h9,
		PS_RESTART_S   = 4'ha,
		PS_OTHER       = 4'hf
	} hpct_port_state_e;

	// port status inputs sampled each cycle
	typedef struct packed {
		hpct_port_state_e state;
		logic             current_connect_status;
		logic             attach_detach_evt;
		logic             port_enable;
		logic             port_error;
		logic             reset_bad_idle;
		logic             over_current;
		logic             remote_oc_power_off;
		logic             resume_driving;
	} hpct_port_s;

	// host request strobes, one bit per change flag
	typedef struct packed {
		logic [CHG_NUM-1:0] clear;
		logic [CHG_NUM-1:0] set;
	} hpct_req_s;

endpackage

// file: design/hpct_tracker.sv
// hpct_tracker: per-port change flags of a downstream facing hub port
// assumes port status and host requests arrive synchronous to mclk
`timescale 1ns/10ps

module hpct_tracker
	import hpct_pkg::*;
#(
	parameter bit OC_PER_PORT    = 1'b1,
	parameter bit DIAG_SET_EN    = 1'b0,
	parameter bit BAD_IDLE_EN    = 1'b1
) (
	input  wire logic              mclk,
	input  wire logic              srst,
	input  wire hpct_port_s        port_in,
	input  wire hpct_req_s         req_in,
	input  wire logic              hub_configured,
	output logic [WORD_W-1:0]      port_change_word
);

	// flag state: one bit per change flag, bit index is the word position
	logic [CHG_NUM-1:0] chg_reg;
	logic [CHG_NUM-1:0] chg_next;

	// edge history: port status as seen one cycle earlier
	hpct_port_state_e   state_reg;
	hpct_port_state_e   state_next;
	logic               enable_reg;
	logic               enable_next;
	logic               oc_reg;
	logic               oc_next;

	// per-cycle decode results
	logic [CHG_NUM-1:0] set_evt;
	logic [CHG_NUM-1:0] hold_zero;
	logic [CHG_NUM-1:0] diag_set;
	logic               powered_off;
	logic               oc_forced_zero;
	logic               enable_err_evt;
	logic               bad_idle_evt;
	logic               resume_evt;
	logic               reset_evt;
	logic               oc_evt;

	// powered-off decode of the port state code
	function automatic logic state_is_off(hpct_port_state_e st);
		logic res;
		res = 1'b0;
		case (st)
			PS_POWERED_OFF: begin
				res = 1'b1;
			end
			default: begin
				res = 1'b0;
			end
		endcase
		return res;
	endfunction

	// enable dropped from one to zero while a port error stood
	function automatic logic enable_fell_on_error(
		logic was_enabled,
		logic is_enabled,
		logic error_seen
	);
		logic fell;
		fell = was_enabled && !is_enabled;
		return fell && error_seen;
	endfunction

	// resume completion transitions; none counts while resume is still driven
	function automatic logic resume_finished(
		hpct_port_state_e prev_st,
		hpct_port_state_e cur_st,
		logic             driving
	);
		logic hit;
		hit = 1'b0;
		case (prev_st)
			PS_RESUMING: begin
				hit = (cur_st == PS_SEND_EOP);
			end
			PS_RESTART_S: begin
				hit = (cur_st == PS_TRANSMIT);
			end
			default: begin
				hit = 1'b0;
			end
		endcase
		return hit && !driving;
	endfunction

	// reset processing done: resetting or speed evaluation into enabled
	function automatic logic reset_finished(
		hpct_port_state_e prev_st,
		hpct_port_state_e cur_st
	);
		logic from_reset;
		from_reset = 1'b0;
		case (prev_st)
			PS_RESETTING: begin
				from_reset = 1'b1;
			end
			PS_SPEED_EVAL: begin
				from_reset = 1'b1;
			end
			default: begin
				from_reset = 1'b0;
			end
		endcase
		return from_reset && (cur_st == PS_ENABLED);
	endfunction

	// any over-current toggle, or power removed by another port's over-current
	function automatic logic oc_changed(
		logic prev_oc,
		logic cur_oc,
		logic remote_off
	);
		logic toggled;
		toggled = (prev_oc != cur_oc);
		return toggled || remote_off;
	endfunction

	// force-zero condition of one flag position
	function automatic logic flag_zero(
		int   idx,
		logic port_off,
		logic oc_zero
	);
		logic res;
		res = 1'b0;
		case (idx)
			BIT_CONNECT: begin
				res = port_off; // R4
			end
			BIT_ENABLE, BIT_SUSPEND, BIT_RESET: begin
				res = port_off; // R12
			end
			BIT_OVERCUR: begin
				res = oc_zero; // R9 R10
			end
			default: begin
				res = 1'b0;
			end
		endcase
		return res;
	endfunction

	// one flag's next value: hold-zero beats set, set beats clear, else hold
	function automatic logic flag_update(
		logic cur,
		logic zero,
		logic set,
		logic clr
	);
		logic nxt;
		nxt = cur;
		if (zero) begin
			nxt = 1'b0;
		end else if (set) begin
			nxt = 1'b1; // R14
		end else if (clr) begin
			nxt = 1'b0; // R4 R9 R12
		end else begin
			nxt = cur; // R1
		end
		return nxt;
	endfunction

	// event decode from the port status against its one-cycle history
	always_comb begin
		powered_off    = state_is_off(port_in.state);
		enable_err_evt = enable_fell_on_error(
			enable_reg,
			port_in.port_enable,
			port_in.port_error); // R5
		bad_idle_evt   = BAD_IDLE_EN && port_in.reset_bad_idle; // R6
		resume_evt     = resume_finished(
			state_reg,
			port_in.state,
			port_in.resume_driving); // R7
		reset_evt      = reset_finished(state_reg, port_in.state); // R11
		oc_evt         = oc_changed(
			oc_reg,
			port_in.over_current,
			port_in.remote_oc_power_off); // R8
	end

	// diagnostic set requests count only when enabled, otherwise a no-op
	always_comb begin
		diag_set = '0;
		if (DIAG_SET_EN) begin
			diag_set = req_in.set; // R2
		end
	end

	// events gathered into the flag positions
	always_comb begin
		set_evt              = '0;
		set_evt[BIT_CONNECT] = port_in.attach_detach_evt; // R3
		set_evt[BIT_ENABLE]  = enable_err_evt || bad_idle_evt; // R5 R6
		set_evt[BIT_SUSPEND] = resume_evt; // R7
		set_evt[BIT_OVERCUR] = oc_evt; // R8
		set_evt[BIT_RESET]   = reset_evt; // R11
		set_evt              = set_evt | diag_set; // R2
	end

	// force-zero conditions per flag
	always_comb begin
		oc_forced_zero = !hub_configured || !OC_PER_PORT; // R9 R10
		hold_zero      = '0;
		for (int i = 0; i < CHG_NUM; i++) begin
			hold_zero[i] = flag_zero(i, powered_off, oc_forced_zero); // R4 R12
		end
	end

	// next value of every change flag
	always_comb begin
		chg_next = chg_reg;
		for (int i = 0; i < CHG_NUM; i++) begin
			chg_next[i] = flag_update(
				chg_reg[i],
				hold_zero[i],
				set_evt[i],
				req_in.clear[i]); // R1 R14
		end
	end

	// change flags, cleared by hub reset
	always_ff @(posedge mclk) begin
		if (srst) begin
			chg_reg <= CHG_RESET_VAL; // R1
		end else begin
			chg_reg <= chg_next;
		end
	end

	// edge history follows the port status every cycle
	always_comb begin
		state_next  = port_in.state;
		enable_next = port_in.port_enable;
		oc_next     = port_in.over_current;
	end

	// history registers; reset mirrors a powered-off, idle port
	always_ff @(posedge mclk) begin
		if (srst) begin
			state_reg  <= PS_POWERED_OFF;
			enable_reg <= 1'b0;
			oc_reg     <= 1'b0;
		end else begin
			state_reg  <= state_next;
			enable_reg <= enable_next;
			oc_reg     <= oc_next;
		end
	end

	// reserved bits read as zero
	assign port_change_word = {{(WORD_W-CHG_NUM){1'b0}}, chg_reg}; // R13

endmodule

// file: sim/hpct_host.sv
// host model: clear and set requests to the change flags
// assumes a fresh random word from the bench each cycle
`timescale 1ns/10ps
module hpct_host
	import hpct_pkg::*;
(
	input wire logic [31:0] rnd,
	input wire logic        mclk,
	output hpct_req_s       req
);
	// one-cycle request pulses, sets as likely as clears
	initial req = '0;
	always @(posedge mclk) req <= '{clear: rnd[4:0] & rnd[9:5], set: rnd[14:10] & rnd[19:15]};
endmodule

// file: sim/hpct_tracker_properties.sv
// checker for the change word of the port change tracker
// assumes it is bound into hpct_tracker
`timescale 1ns/10ps
module hpct_tracker_chk
	import hpct_pkg::*;
#(
	parameter bit OC_PER_PORT = 1'b1,
	parameter bit DIAG_SET_EN = 1'b0,
	parameter bit BAD_IDLE_EN = 1'b1
) (
	input wire logic              mclk,
	input wire logic              srst,
	input wire hpct_port_s        port_in,
	input wire hpct_req_s         req_in,
	input wire logic              hub_configured,
	input wire logic [WORD_W-1:0] port_change_word
);
	// short aliases; all checks on mclk, quiet in reset
	wire hpct_port_s p = port_in;
	wire logic [WORD_W-1:0] w = port_change_word;
	wire logic off = port_in.state == PS_POWERED_OFF;
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	chk_reserved_zero: assert property (w[15:5] == 11'h000) else $error("reserved set");
	chk_connect_set: assert property (p.attach_detach_evt && !off |=> w[0]) else $error("c0");
	chk_flag_hold: assert property (w[0] && !req_in.clear[0] && !off |=> w[0]) else $error("h0");
	chk_connect_clear: assert property (req_in.clear[0] && !p.attach_detach_evt
		&& !(DIAG_SET_EN && req_in.set[0]) |=> !w[0]) else $error("k0");
	chk_set_noop: assert property (!DIAG_SET_EN && req_in.set[0] && !w[0]
		&& !p.attach_detach_evt |=> !w[0]) else $error("set no-op");
	chk_oc_absent: assert property (!OC_PER_PORT |-> !w[3]) else $error("oc absent");
	chk_enable_err: assert property (!$past(srst) && $past(p.port_enable) && !p.port_enable
		&& p.port_error && !off |=> w[1]) else $error("en");
	chk_resume_done: assert property (!$past(srst) && $past(p.state) == PS_RESUMING
		&& p.state == PS_SEND_EOP && !p.resume_driving |=> w[2]) else $error("sus");
	chk_power_off: assert property (off |=> !w[4] && w[2:0] == 3'h0) else $error("off");
	chk_unconfig_oc: assert property (!hub_configured |=> !w[3]) else $error("cfg");
	chk_oc_edge: assert property (OC_PER_PORT && hub_configured && $changed(p.over_current)
		&& !$past(srst)
		|=> w[3]) else $error("oc");
	chk_reset_done: assert property (!$past(srst) && $past(p.state) == PS_RESETTING
		&& p.state == PS_ENABLED |=> w[4]) else $error("rst");
	// main scenarios reached
	cover property (p.attach_detach_evt && req_in.clear[0] && !off);
	cover property ($rose(w[2]));
	cover property (w[3] && req_in.clear[3]);
	cover property ($rose(w[4]));
endmodule
bind hpct_tracker hpct_tracker_chk #(.OC_PER_PORT(OC_PER_PORT), .DIAG_SET_EN(DIAG_SET_EN),
	.BAD_IDLE_EN(BAD_IDLE_EN)) hpct_tracker_chk_i (.mclk(mclk), .srst(srst), .port_in(port_in),
	.req_in(req_in), .hub_configured(hub_configured), .port_change_word(port_change_word));

// file: sim/tb_hpct_tracker.sv
// bench: random port activity and host requests against a flag model
// assumes the tracker, host model and checker are compiled first
`timescale 1ns/10ps
`define CHK(e, s) begin n_tests++; if ((s) !== (e)) begin bad_count++; \
	$display("wrong value port_change_word exp %h got %h", e, s); end end
module tb_hpct_tracker
	import hpct_pkg::*;
;
	logic mclk = 0, srst = 1, cfg = 0, pen = 0, poc = 0;
	hpct_port_s pin = '0;
	hpct_port_state_e ps = PS_POWERED_OFF;
	hpct_req_s req;
	logic [15:0] word, word_alt, exp = '0, exp_alt = '0;
	logic [31:0] x = 98;
	int bad_count = 0, n_tests = 0, cyc = 0;
	always #5 mclk = ~mclk;
	function automatic logic [31:0] xs(logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		return v ^ (v << 5);
	endfunction
	// next flags from the inputs sampled at this edge
	function automatic logic [4:0] nxt(logic [4:0] f, bit diag, bit ocpp, bit bi);
		logic [4:0] e;
		e[0] = pin.attach_detach_evt;
		e[1] = pen & ~pin.port_enable & pin.port_error | bi & pin.reset_bad_idle;
		e[2] = !pin.resume_driving && (ps == PS_RESUMING && pin.state == PS_SEND_EOP
			|| ps == PS_RESTART_S && pin.state == PS_TRANSMIT);
		e[3] = (poc != pin.over_current) | pin.remote_oc_power_off;
		e[4] = (ps == PS_RESETTING || ps == PS_SPEED_EVAL) && pin.state == PS_ENABLED;
		f = f & ~req.clear | e | (diag ? req.set : 5'h00);
		if (pin.state == PS_POWERED_OFF) f &= 5'h08;
		if (!cfg || !ocpp) f[3] = 1'b0;
		return f;
	endfunction
	// model update and new stimulus, mid-run reset at cycle 400
	always @(posedge mclk) begin
		x <= xs(x);
		exp <= srst ? '0 : {11'h000, nxt(exp[4:0], 1'b0, 1'b1, 1'b1)};
		exp_alt <= srst ? '0 : {11'h000, nxt(exp_alt[4:0], 1'b1, 1'b0, 1'b0)};
		ps <= srst ? PS_POWERED_OFF : pin.state;
		pen <= !srst & pin.port_enable;
		poc <= !srst & pin.over_current;
		cyc <= cyc + 1;
		srst <= cyc < 8 || cyc == 400 || x[31:24] == 8'h00;
		cfg <= x[22:20] != 3'h0;
		pin <= {hpct_port_state_e'(4'((x[0] ? pin.state + 1 : x[7:4]) % 11)), x[15:8]};
	end
	// compare once the word has settled
	always @(negedge mclk) if (cyc > 1) begin
		`CHK(exp, word)
		`CHK(exp_alt, word_alt)
	end
	hpct_host hpct_host_i (.rnd(x), .mclk(mclk), .req(req));
	hpct_tracker hpct_tracker_i (.mclk(mclk), .srst(srst), .port_in(pin), .req_in(req),
		.hub_configured(cfg), .port_change_word(word));
	// second build: diagnostic set on, no per-port over-current, no bad-idle flag
	hpct_tracker #(.OC_PER_PORT(1'b0), .DIAG_SET_EN(1'b1), .BAD_IDLE_EN(1'b0)) hpct_tracker_alt_i (
		.mclk(mclk), .srst(srst), .port_in(pin), .req_in(req),
		.hub_configured(cfg), .port_change_word(word_alt));
	task automatic test_done;
		$display("mismatches %0d of %0d checks", bad_count, n_tests);
		if (bad_count == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (4000) @(posedge mclk);
		test_done;
	end
endmodule
